// file: design/ewfc_ctrl.v
// Purpose: Host controller driving the embedded word flash through its pins
// Assumes: AHB-Lite single word transfers; one flash on array_enable_n
// Notes: Software writes ADDR/WDATA then CMD; polls STATUS
`timescale 1ns/100ps
`include "ewfc_defines.vh"

////////////////////////////////////////////////////////////////////////////////
module ewfc_ctrl #(
    parameter POWER_ON_CYC = `EWFC_POWER_ON_CYC,
    parameter TIMEOUT_CYC = `EWFC_TIMEOUT_CYC
) (
    input wire clock,
    input wire arst_n,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg hresp,
    output reg [31:0] hrdata,
    output reg [20:1] flash_addr,
    output reg [15:0] flash_dq_o,
    output reg flash_dq_oe,
    input wire [15:0] flash_dq_i,
    output reg array_enable_n,
    output reg flash_oe_n,
    output reg flash_we_n,
    output reg array_reset_n,
    input wire cycle_active_n,
    input wire supply_ok
);
    ////////////////////////////////////////////////////////////////////////////
    localparam S_IDLE = 4'd0;
    localparam S_WSET = 4'd1;
    localparam S_WPULSE = 4'd2;
    localparam S_WHOLD = 4'd3;
    localparam S_RSET = 4'd4;
    localparam S_RWAIT = 4'd5;
    localparam S_NEXT = 4'd6;
    localparam S_POLL = 4'd7;
    localparam S_RST = 4'd8;
    localparam S_GAP = 4'd9;

    reg [3:0] st_q;
    reg [2:0] op_q;
    reg [2:0] step_q;
    reg [19:0] addr_q;
    reg [15:0] wdata_q;
    reg [15:0] rdata_q;
    reg [31:0] cfg_q;
    reg bypass_q;
    reg timeout_q;
    reg done_q;
    reg [31:0] cnt_q;
    reg [31:0] pwr_q;
    reg pwr_ok_q;
    reg [15:0] poll_q;
    reg pend_q;
    reg [7:0] ap_addr_q;
    reg ap_wr_q;
    reg ap_q;
    reg [19:0] seq_a;
    reg [15:0] seq_d;
    reg seq_last;
    wire busy_sync;
    wire supply_sync;
    wire busy = (st_q != S_IDLE);
    wire wr_window = ap_q && ap_wr_q;

    ewfc_sync #(.RESET_VAL(1'b1)) u_busy_sync (
        .clock(clock),
        .arst_n(arst_n),
        .din(cycle_active_n),
        .dout(busy_sync)
    );
    ewfc_sync #(.RESET_VAL(1'b0)) u_supply_sync (
        .clock(clock),
        .arst_n(arst_n),
        .din(supply_ok),
        .dout(supply_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Command sequence table: step -> unlock address and data
    always @* begin
        seq_a = `EWFC_UNLOCK_A1;
        seq_d = `EWFC_UNLOCK_D1;
        seq_last = 1'b0;
        case (op_q)
            `EWFC_OP_PROG: begin
                if (bypass_q) begin
                    // Bypass mode: one command word then the data write
                    seq_d = `EWFC_CMD_PROG;
                    if (step_q == 3'd1) begin
                        seq_a = addr_q;
                        seq_d = wdata_q;
                        seq_last = 1'b1;
                    end
                end else begin
                    case (step_q)
                        3'd0: seq_d = `EWFC_UNLOCK_D1;
                        3'd1: begin seq_a = `EWFC_UNLOCK_A2; seq_d = `EWFC_UNLOCK_D2; end
                        3'd2: seq_d = `EWFC_CMD_PROG;
                        default: begin seq_a = addr_q; seq_d = wdata_q; seq_last = 1'b1; end
                    endcase
                end
            end
            `EWFC_OP_SECT_ERASE: begin
                case (step_q)
                    3'd0: seq_d = `EWFC_UNLOCK_D1;
                    3'd1: begin seq_a = `EWFC_UNLOCK_A2; seq_d = `EWFC_UNLOCK_D2; end
                    3'd2: seq_d = `EWFC_CMD_ERASE;
                    3'd3: seq_d = `EWFC_UNLOCK_D1;
                    3'd4: begin seq_a = `EWFC_UNLOCK_A2; seq_d = `EWFC_UNLOCK_D2; end
                    default: begin seq_a = addr_q; seq_d = `EWFC_CMD_SECT; seq_last = 1'b1; end
                endcase
            end
            `EWFC_OP_BYPASS: begin
                case (step_q)
                    3'd0: seq_d = `EWFC_UNLOCK_D1;
                    3'd1: begin seq_a = `EWFC_UNLOCK_A2; seq_d = `EWFC_UNLOCK_D2; end
                    default: begin seq_d = `EWFC_CMD_BYPASS; seq_last = 1'b1; end
                endcase
            end
            `EWFC_OP_SUSPEND: begin
                seq_a = addr_q;
                seq_d = `EWFC_CMD_SUSPEND;
                seq_last = 1'b1;
            end
            `EWFC_OP_RESUME: begin
                seq_a = addr_q;
                seq_d = `EWFC_CMD_RESUME;
                seq_last = 1'b1;
            end
            default: begin
                seq_d = `EWFC_CMD_RESET;
                seq_last = 1'b1;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Supply qualification before any write reaches the array
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pwr_q <= 32'h0000_0000;
            pwr_ok_q <= 1'b0;
        end else if (!supply_sync) begin
            pwr_q <= 32'h0000_0000;
            pwr_ok_q <= 1'b0;
        end else if (pwr_q >= POWER_ON_CYC) begin
            pwr_ok_q <= 1'b1;
        end else begin
            pwr_q <= pwr_q + 32'h0000_0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave, zero wait state; commands while busy are dropped
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ap_q <= 1'b0;
            ap_wr_q <= 1'b0;
            ap_addr_q <= 8'h00;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h0000_0000;
        end else begin
            ap_q <= hsel && htrans[1] && hready;
            ap_wr_q <= hwrite;
            ap_addr_q <= haddr[7:0];
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (hsel && htrans[1] && hready && !hwrite) begin
                if (haddr[7:0] == `EWFC_REG_ADDR) begin
                    hrdata <= {12'h000, addr_q};
                end else if (haddr[7:0] == `EWFC_REG_WDATA) begin
                    hrdata <= {16'h0000, wdata_q};
                end else if (haddr[7:0] == `EWFC_REG_STATUS) begin
                    hrdata <= {27'h0, done_q, timeout_q, bypass_q, ~busy_sync, busy};
                end else if (haddr[7:0] == `EWFC_REG_RDATA) begin
                    hrdata <= {16'h0000, rdata_q};
                end else if (haddr[7:0] == `EWFC_REG_CFG) begin
                    hrdata <= cfg_q;
                end else begin
                    hrdata <= 32'h0000_0000;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flash pin sequencer
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= S_IDLE;
            op_q <= 3'h0;
            step_q <= 3'h0;
            addr_q <= 20'h00000;
            wdata_q <= 16'h0000;
            rdata_q <= 16'h0000;
            cfg_q <= `EWFC_CFG_RESET;
            bypass_q <= 1'b0;
            timeout_q <= 1'b0;
            done_q <= 1'b0;
            cnt_q <= 32'h0000_0000;
            poll_q <= 16'h0000;
            pend_q <= 1'b0;
            flash_addr <= 20'h00000;
            flash_dq_o <= 16'h0000;
            flash_dq_oe <= 1'b0;
            array_enable_n <= 1'b1;
            flash_oe_n <= 1'b1;
            flash_we_n <= 1'b1;
            array_reset_n <= 1'b0;
        end else begin
            pend_q <= 1'b0;
            if (wr_window && ap_addr_q == `EWFC_REG_ADDR && !busy) begin
                addr_q <= hwdata[19:0];
            end
            if (wr_window && ap_addr_q == `EWFC_REG_WDATA && !busy) begin
                wdata_q <= hwdata[15:0];
            end
            if (wr_window && ap_addr_q == `EWFC_REG_CFG) begin
                cfg_q <= {27'h0, hwdata[`EWFC_CFG_POLL_BIT], hwdata[3:0]};
            end
            case (st_q)
                S_IDLE: begin
                    array_reset_n <= 1'b1;
                    if (wr_window && ap_addr_q == `EWFC_REG_CMD && hwdata[2:0] != 3'h0) begin
                        op_q <= hwdata[2:0];
                        step_q <= 3'h0;
                        done_q <= 1'b0;
                        timeout_q <= 1'b0;
                        cnt_q <= 32'h0000_0000;
                        if (hwdata[2:0] == `EWFC_OP_RESET) begin
                            array_reset_n <= 1'b0;
                            st_q <= S_RST;
                        end else if (hwdata[2:0] == `EWFC_OP_READ) begin
                            st_q <= S_RSET;
                        end else if (pwr_ok_q) begin
                            st_q <= S_WSET;
                        end else begin
                            timeout_q <= 1'b1;
                            done_q <= 1'b1;
                        end
                    end
                end
                S_RST: begin
                    // Pulse held past the minimum, clears bypass mode
                    cnt_q <= cnt_q + 32'h0000_0001;
                    if (cnt_q >= `EWFC_RESET_CYC) begin
                        array_reset_n <= 1'b1;
                        bypass_q <= 1'b0;
                        done_q <= 1'b1;
                        st_q <= S_IDLE;
                    end
                end
                S_WSET: begin
                    flash_addr <= seq_a;
                    flash_dq_o <= seq_d;
                    flash_dq_oe <= 1'b1;
                    flash_oe_n <= 1'b1;
                    array_enable_n <= 1'b0;
                    cnt_q <= 32'h0000_0000;
                    st_q <= S_WPULSE;
                end
                S_WPULSE: begin
                    // Pulse well above the noise filter width
                    flash_we_n <= 1'b0;
                    cnt_q <= cnt_q + 32'h0000_0001;
                    if (cnt_q >= `EWFC_STROBE_CYC) begin
                        flash_we_n <= 1'b1;
                        cnt_q <= 32'h0000_0000;
                        st_q <= S_WHOLD;
                    end
                end
                S_WHOLD: begin
                    array_enable_n <= 1'b1;
                    flash_dq_oe <= 1'b0;
                    if (seq_last) begin
                        st_q <= S_NEXT;
                    end else begin
                        step_q <= step_q + 3'd1;
                        st_q <= S_WSET;
                    end
                end
                S_NEXT: begin
                    if (op_q == `EWFC_OP_BYPASS) begin
                        bypass_q <= 1'b1;
                        done_q <= 1'b1;
                        st_q <= S_IDLE;
                    end else if (op_q == `EWFC_OP_PROG || op_q == `EWFC_OP_SECT_ERASE) begin
                        poll_q <= wdata_q;
                        cnt_q <= 32'h0000_0000;
                        st_q <= S_POLL;
                    end else begin
                        done_q <= 1'b1;
                        st_q <= S_IDLE;
                    end
                end
                S_POLL: begin
                    // Busy pin wait; host commands are dropped until the sequencer is back in idle
                    cnt_q <= cnt_q + 32'h0000_0001;
                    if (cnt_q >= 32'd4 && busy_sync) begin
                        st_q <= (op_q == `EWFC_OP_PROG && cfg_q[`EWFC_CFG_POLL_BIT]) ? S_RSET : S_GAP;
                    end else if (cnt_q >= TIMEOUT_CYC) begin
                        timeout_q <= 1'b1;
                        st_q <= S_GAP;
                    end
                end
                S_RSET: begin
                    flash_addr <= addr_q;
                    flash_dq_oe <= 1'b0;
                    array_enable_n <= 1'b0;
                    flash_oe_n <= 1'b0;
                    cnt_q <= 32'h0000_0000;
                    st_q <= S_RWAIT;
                end
                S_RWAIT: begin
                    // Wait states cover the array access time at this clock
                    cnt_q <= cnt_q + 32'h0000_0001;
                    if (cnt_q >= {28'h0, cfg_q[3:0]} + `EWFC_STROBE_CYC) begin
                        rdata_q <= flash_dq_i;
                        array_enable_n <= 1'b1;
                        flash_oe_n <= 1'b1;
                        pend_q <= 1'b1;
                        st_q <= S_GAP;
                    end
                end
                S_GAP: begin
                    if (pend_q && op_q == `EWFC_OP_PROG && rdata_q[7] != poll_q[7]) begin
                        st_q <= S_RSET;
                    end else begin
                        done_q <= 1'b1;
                        st_q <= S_IDLE;
                    end
                end
                default: begin
                    st_q <= S_IDLE;
                end
            endcase
        end
    end
endmodule // ewfc_ctrl

// file: design/ewfc_defines.vh
// Purpose: Constants for the flash array controller (host side)
// Assumes: 125 MHz clock, AHB-Lite register port, word-wide flash pins
// Notes: Offsets are byte addresses of 32-bit words
`ifndef EWFC_DEFINES_VH
`define EWFC_DEFINES_VH

`define EWFC_CLK_PERIOD_PS 8000
// Register offsets
`define EWFC_REG_CMD 8'h00
`define EWFC_REG_ADDR 8'h04
`define EWFC_REG_WDATA 8'h08
`define EWFC_REG_STATUS 8'h0C
`define EWFC_REG_RDATA 8'h10
`define EWFC_REG_CFG 8'h14
// Command codes in CMD[2:0]
`define EWFC_OP_READ 3'h1
`define EWFC_OP_PROG 3'h2
`define EWFC_OP_SECT_ERASE 3'h3
`define EWFC_OP_SUSPEND 3'h4
`define EWFC_OP_RESUME 3'h5
`define EWFC_OP_BYPASS 3'h6
`define EWFC_OP_RESET 3'h7
// Status bits
`define EWFC_ST_BUSY 0
`define EWFC_ST_ARRAY_BUSY 1
`define EWFC_ST_BYPASS 2
`define EWFC_ST_TIMEOUT 3
`define EWFC_ST_DONE 4
// Config fields
`define EWFC_CFG_WAIT_LSB 0
`define EWFC_CFG_WAIT_W 4
`define EWFC_CFG_POLL_BIT 4
`define EWFC_CFG_RESET 32'h0000_0005
// Flash command bytes and unlock addresses (word addresses)
`define EWFC_UNLOCK_A1 20'h00555
`define EWFC_UNLOCK_A2 20'h002AA
`define EWFC_UNLOCK_D1 16'h00AA
`define EWFC_UNLOCK_D2 16'h0055
`define EWFC_CMD_PROG 16'h00A0
`define EWFC_CMD_ERASE 16'h0080
`define EWFC_CMD_SECT 16'h0030
`define EWFC_CMD_SUSPEND 16'h00B0
`define EWFC_CMD_RESUME 16'h0030
`define EWFC_CMD_BYPASS 16'h0020
`define EWFC_CMD_RESET 16'h00F0
// Times
`define EWFC_RESET_LOW_NS 50
`define EWFC_RESET_CYC ((`EWFC_RESET_LOW_NS * 1000 + `EWFC_CLK_PERIOD_PS - 1) / `EWFC_CLK_PERIOD_PS)
`define EWFC_STROBE_NS 40
`define EWFC_STROBE_CYC ((`EWFC_STROBE_NS * 1000 + `EWFC_CLK_PERIOD_PS - 1) / `EWFC_CLK_PERIOD_PS)
`define EWFC_POWER_ON_MS 10
// Worked in ns per clock so the product stays inside 32 bits
`define EWFC_POWER_ON_CYC (`EWFC_POWER_ON_MS * 1000000 / (`EWFC_CLK_PERIOD_PS / 1000))
`define EWFC_TIMEOUT_CYC 32'd50000000
`endif

// file: design/ewfc_sync.v
// Purpose: Three-flop input synchroniser with agreement filter
// Assumes: Input is asynchronous to clock
// Notes: Output changes once stages two and three agree
`timescale 1ns/100ps
module ewfc_sync #(
    parameter RESET_VAL = 1'b1
) (
    input wire clock,
    input wire arst_n,
    input wire din,
    output reg dout
);
    reg s1_q;
    reg s2_q;
    reg s3_q;
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s1_q <= RESET_VAL;
            s2_q <= RESET_VAL;
            s3_q <= RESET_VAL;
            dout <= RESET_VAL;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                dout <= s3_q;
            end
        end
    end
endmodule // ewfc_sync

// file: tb/ewfc_ctrl_checker.sv
// Purpose: Pin and bus timing checks for the flash controller
// Assumes: Sees only the top-level ports; one clock domain
// Notes: Counts follow the strobe timing of the controller
`timescale 1ns/100ps
module ewfc_ctrl_checker #(
    parameter POWER_ON_CYC = 1250000,
    parameter TIMEOUT_CYC = 50000000
) (
    input wire clock,
    input wire arst_n,
    input wire hreadyout,
    input wire hresp,
    input wire [20:1] flash_addr,
    input wire [15:0] flash_dq_o,
    input wire flash_dq_oe,
    input wire array_enable_n,
    input wire flash_oe_n,
    input wire flash_we_n,
    input wire array_reset_n
);
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////////////////////////////////////////////
    okay_resp_a:
        assert property (!hresp) else $error("Bus response not okay");
    zero_wait_a:
        assert property (hreadyout) else $error("Bus stalled");
    reset_hold_a:
        assert property ($fell(array_reset_n) |-> !array_reset_n [*7]) else $error("Array reset pulse short");
    we_width_a:
        assert property ($fell(flash_we_n) |-> !flash_we_n [*5] ##1 flash_we_n) else $error("Write pulse width");
    we_setup_a:
        assert property ($fell(flash_we_n) |-> $past(array_enable_n) == 1'b0) else $error("Enable not set up");
    we_qual_a:
        assert property (!flash_we_n |-> !array_enable_n && flash_oe_n) else $error("Write strobe unqualified");
    we_stable_a:
        assert property (!flash_we_n |-> flash_dq_oe && $stable(flash_addr) && $stable(flash_dq_o))
        else $error("Write data moved");
    read_wait_a:
        assert property ($fell(flash_oe_n) |-> (!flash_oe_n && !array_enable_n) [*6]) else $error("Read too short");
    read_float_a:
        assert property (!flash_oe_n |-> !flash_dq_oe) else $error("Bus driven during read");
    reset_quiet_a:
        assert property (!array_reset_n |-> flash_we_n && flash_oe_n) else $error("Strobe during array reset");
    cover property ($fell(flash_we_n));
    cover property ($fell(flash_oe_n));
    cover property ($fell(array_reset_n));
endmodule // ewfc_ctrl_checker

bind ewfc_ctrl ewfc_ctrl_checker #(.POWER_ON_CYC(POWER_ON_CYC), .TIMEOUT_CYC(TIMEOUT_CYC)) i_chk (
    .clock(clock), .arst_n(arst_n), .hreadyout(hreadyout), .hresp(hresp), .flash_addr(flash_addr),
    .flash_dq_o(flash_dq_o), .flash_dq_oe(flash_dq_oe), .array_enable_n(array_enable_n),
    .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .array_reset_n(array_reset_n));

// file: tb/ewfc_flash_model.sv
// Purpose: Behavioural word flash seen through its pins
// Assumes: Clock paces the busy time and the released-bus pattern
// Notes: stuck_busy holds the busy pin low to force a hang
`timescale 1ns/100ps
module ewfc_flash_model #(
    parameter BUSY_CYC = 30
) (
    input wire clock,
    input wire [20:1] flash_addr,
    input wire [15:0] flash_dq_o,
    input wire flash_dq_oe,
    input wire array_enable_n,
    input wire flash_oe_n,
    input wire flash_we_n,
    input wire array_reset_n,
    input wire supply_ok,
    input wire stuck_busy,
    output logic [15:0] flash_dq_i,
    output wire cycle_active_n
);
    logic [15:0] mem [int];
    logic [15:0] last_q = 16'h0000;
    logic [15:0] rel_q = 16'hA5A5;
    logic [19:0] last_a = 20'h00000;
    logic bypass = 1'b0;
    int step = 0;
    int busy_cnt = 0;
    realtime t_low = 0;
    function automatic logic [15:0] rd(input logic [19:0] a);
        return mem.exists(a) ? mem[a] : 16'hFFFF;
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    assign cycle_active_n = !(busy_cnt != 0 || stuck_busy);
    always @(posedge clock) begin
        rel_q <= ~rel_q;
        if (busy_cnt > 0)
            busy_cnt--;
    end
    // Released bus shows a changing pattern, never the old value
    always_comb begin
        if (!array_enable_n && !flash_oe_n && array_reset_n && !flash_dq_oe)
            flash_dq_i = (busy_cnt != 0 && flash_addr == last_a) ? last_q ^ 16'h0080 : rd(flash_addr);
        else
            flash_dq_i = rel_q;
    end
    always @(negedge array_reset_n) begin
        t_low = $realtime;
        step = 0;
        busy_cnt = 0;
    end
    always @(posedge array_reset_n) begin
        if ($realtime - t_low >= 50.0)
            bypass = 1'b0;
    end
    // Write taken at the end of the strobe; out-of-order data falls back to read mode
    always @(posedge flash_we_n) begin
        if (!array_enable_n && flash_oe_n && array_reset_n && supply_ok && busy_cnt == 0) begin
            case (step)
                0: step = (flash_addr == 20'h00555 && flash_dq_o == 16'h00AA) ? 1 : (bypass && flash_dq_o == 16'h00A0) ? 10 : 0;
                1, 4: step = (flash_addr == 20'h002AA && flash_dq_o == 16'h0055) ? step + 1 : 0;
                2: begin
                    bypass = bypass | (flash_dq_o == 16'h0020);
                    step = (flash_dq_o == 16'h00A0) ? 10 : (flash_dq_o == 16'h0080) ? 3 : 0;
                end
                3: step = (flash_addr == 20'h00555 && flash_dq_o == 16'h00AA) ? 4 : 0;
                5: begin
                    if (flash_dq_o == 16'h0030) begin
                        foreach (mem[k])
                            if (k[19:15] == flash_addr[20:16])
                                mem[k] = 16'hFFFF;
                        busy_cnt = BUSY_CYC;
                    end
                    step = 0;
                end
                default: begin
                    mem[flash_addr] = rd(flash_addr) & flash_dq_o;
                    last_a = flash_addr;
                    last_q = flash_dq_o;
                    busy_cnt = BUSY_CYC;
                    step = 0;
                end
            endcase
        end
    end
endmodule // ewfc_flash_model

// file: tb/embedded_word_flash_array_tb.sv
// Purpose: Self-checking bench for the flash controller
// Assumes: Single AHB-Lite master; model flash on the pins
// Notes: Short power-on and timeout counts for run time
`timescale 1ns/100ps
`include "ewfc_defines.vh"
module embedded_word_flash_array_tb;
    logic clock = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, supply_ok = 1'b0, stuck_busy = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, st;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [19:0] a;
    logic [15:0] d;
    wire hready, hreadyout, hresp, flash_dq_oe, array_enable_n, flash_oe_n, flash_we_n, array_reset_n, cycle_active_n;
    wire [31:0] hrdata;
    wire [20:1] flash_addr;
    wire [15:0] flash_dq_o, flash_dq_i;
    int num_errors = 0, check_count = 0, cycles = 0, we_cnt = 0;
    assign hready = hreadyout;
    ewfc_ctrl #(.POWER_ON_CYC(20), .TIMEOUT_CYC(2000)) i_dut (.clock(clock), .arst_n(arst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .flash_addr(flash_addr), .flash_dq_o(flash_dq_o),
        .flash_dq_oe(flash_dq_oe), .flash_dq_i(flash_dq_i), .array_enable_n(array_enable_n),
        .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .array_reset_n(array_reset_n),
        .cycle_active_n(cycle_active_n), .supply_ok(supply_ok));
    ewfc_flash_model #(.BUSY_CYC(30)) i_model (.clock(clock), .flash_addr(flash_addr), .flash_dq_o(flash_dq_o),
        .flash_dq_oe(flash_dq_oe), .array_enable_n(array_enable_n), .flash_oe_n(flash_oe_n),
        .flash_we_n(flash_we_n), .array_reset_n(array_reset_n), .supply_ok(supply_ok),
        .stuck_busy(stuck_busy), .flash_dq_i(flash_dq_i), .cycle_active_n(cycle_active_n));
    ////////////////////////////////////////////////////////////////////////////////
    initial forever #4 clock = ~clock;
    always @(negedge flash_we_n) we_cnt++;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 30000) begin
            num_errors++;
            summarize();
        end
    end
    task automatic summarize;
        if (num_errors == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic int writes(input logic [2:0] c, input logic byp);
        case (c)
            `EWFC_OP_PROG: return byp ? 2 : 4;
            `EWFC_OP_SECT_ERASE: return 6;
            `EWFC_OP_BYPASS: return 3;
            `EWFC_OP_SUSPEND, `EWFC_OP_RESUME: return 1;
            default: return 0;
        endcase
    endfunction
    task automatic ahb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, ad};
        @(posedge clock);
        while (hready !== 1'b1) @(posedge clock);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        @(posedge clock);
        while (hready !== 1'b1) @(posedge clock);
        rd = hrdata;
    endtask
    task automatic op(input logic [2:0] c, input logic [19:0] ad, input logic [15:0] wd);
        int n;
        logic byp;
        n = we_cnt;
        byp = i_model.bypass;
        ahb(1'b1, `EWFC_REG_ADDR, {12'h0, ad});
        ahb(1'b1, `EWFC_REG_WDATA, {16'h0, wd});
        ahb(1'b1, `EWFC_REG_CMD, {29'h0, c});
        st = 32'h1;
        while (st[0] !== 1'b0 || st[4] !== 1'b1) begin
            ahb(1'b0, `EWFC_REG_STATUS, 32'h0);
            st = rd;
        end
        if (st[3] === 1'b0)
            check(we_cnt - n, writes(c, byp));
    endtask
    task automatic rdw(input logic [19:0] ad);
        op(`EWFC_OP_READ, ad, 16'h0000);
        ahb(1'b0, `EWFC_REG_RDATA, 32'h0);
    endtask
    initial begin
        void'($urandom(32'h2A0C7970));
        repeat (8) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        ahb(1'b0, `EWFC_REG_CFG, 32'h0);
        check(rd, `EWFC_CFG_RESET);
        ahb(1'b1, 8'h20, 32'hFFFFFFFF);
        ahb(1'b0, 8'h20, 32'h0);
        check(rd, 32'h0);
        op(`EWFC_OP_PROG, 20'h00100, 16'h1234);
        check(st[4:3], 2'h3);
        rdw(20'h00100);
        check(rd, 32'h0000FFFF);
        supply_ok <= 1'b1;
        op(`EWFC_OP_PROG, 20'h00100, 16'h1234);
        check(st[4:3], 2'h3);
        repeat (40) @(posedge clock);
        ahb(1'b1, `EWFC_REG_CFG, {27'h0, 5'($urandom)});
        for (int i = 0; i < 6; i++) begin
            a = (i == 0) ? 20'h00000 : (i == 1) ? 20'hFFFFF : 20'($urandom);
            d = 16'($urandom);
            op(`EWFC_OP_PROG, a, d);
            check(st[3], 1'b0);
            rdw(a);
            check(rd, {16'h0, d});
        end
        op(`EWFC_OP_SECT_ERASE, a, 16'h0000);
        rdw(a);
        check(rd, 32'h0000FFFF);
        op(`EWFC_OP_SUSPEND, a, 16'h0000);
        op(`EWFC_OP_RESUME, a, 16'h0000);
        check(st[3], 1'b0);
        op(`EWFC_OP_BYPASS, 20'h00000, 16'h0000);
        check(st[2], 1'b1);
        op(`EWFC_OP_PROG, a, 16'h3C5A);
        rdw(a);
        check(rd, 32'h00003C5A);
        op(`EWFC_OP_RESET, 20'h00000, 16'h0000);
        check(st[2], 1'b0);
        check(i_model.bypass, 1'b0);
        stuck_busy <= 1'b1;
        op(`EWFC_OP_PROG, 20'h00200, 16'h00FF);
        check(st[3], 1'b1);
        stuck_busy <= 1'b0;
        repeat (40) @(posedge clock);
        rdw(20'h00200);
        check(rd, 32'h000000FF);
        summarize();
    end
endmodule // embedded_word_flash_array_tb
